// ### core/irqsync_defs.svh
/*
 * register offsets, field positions, reset values and the period counter width for the
 * interrupt routing and sync monitor block. assumes an 8-bit register port.
 */
`ifndef IRQSYNC_DEFS_SVH
`define IRQSYNC_DEFS_SVH

`define IRQSYNC_ADDR_W           12
`define IRQSYNC_OFS_DAC1_SEL     12'h0_02A
`define IRQSYNC_OFS_CLK_SEL      12'h0_02B
`define IRQSYNC_OFS_SUMMARY      12'h0_02C
`define IRQSYNC_OFS_EVT_EN       12'h0_030
`define IRQSYNC_OFS_EVT_STAT     12'h0_031
`define IRQSYNC_OFS_JIT_EN       12'h0_032
`define IRQSYNC_OFS_JIT_STAT     12'h0_033
`define IRQSYNC_OFS_JIT_SEL      12'h0_034
`define IRQSYNC_OFS_SKIP         12'h0_036
`define IRQSYNC_OFS_JIT_TOL      12'h0_039
`define IRQSYNC_OFS_MODE         12'h0_03A

`define IRQSYNC_BIT_PAERR        0
`define IRQSYNC_BIT_PLL_LOCK     0
`define IRQSYNC_BIT_PLL_LOST     1
`define IRQSYNC_BIT_DLL_LOCK     4
`define IRQSYNC_BIT_DLL_LOST     5
`define IRQSYNC_BIT_ONESHOT      1
`define IRQSYNC_BIT_ROT_DONE     4
`define IRQSYNC_CLK_MASK         8'h3_3
`define IRQSYNC_TOL_MASK         8'h7_F
`define IRQSYNC_RST_BYTE         8'h0_0
`define IRQSYNC_RST_ROT_DONE     1'b1
`define IRQSYNC_PERIOD_W         16

`endif

// ### core/irqsync_pkg.sv
/*
 * types shared by the interrupt routing and sync monitor block.
 * assumes irqsync_defs.svh for the numeric constants.
 */
package irqsync_pkg;
  // event sources, one bit each
  typedef struct packed {
    logic pa_error_b;
    logic delay_loop_lost;
    logic delay_loop_locked;
    logic synth_lock_lost;
    logic synth_locked;
  } irqsync_evt_s;

  typedef enum logic [1:0] {
    IRQSYNC_WAIT  = 2'b00,
    IRQSYNC_SKIP  = 2'b01,
    IRQSYNC_MON   = 2'b10
  } irqsync_sync_e;
endpackage

// ### core/irqsync_top.sv
/*
 * interrupt pin routing, summary status and sync edge monitor.
 * assumes a plain 8-bit register port on sys_clk_i, event sources and the
 * sync edge arriving asynchronously, and a host that watches two low pins.
 */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "irqsync_defs.svh"

module irqsync_top #(
  parameter int N_EVT    = 5,
  parameter int PERIOD_W = `IRQSYNC_PERIOD_W
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [`IRQSYNC_ADDR_W-1:0]    reg_addr_i,
  input  wire logic [7:0]                    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [7:0]                    reg_rdata_o,
  input  wire irqsync_pkg::irqsync_evt_s     evt_i,
  input  wire logic                          sync_edge_i,
  output logic                               rotate_pulse_o,
  output logic                               interrupt_pin_a_n_o,
  output logic                               interrupt_pin_b_n_o,
  output logic                               irq_o
);
  import irqsync_pkg::*;

  // event vector order: 4 pa, 3 dll lost, 2 dll lock, 1 pll lost, 0 pll lock
  logic [N_EVT-1:0]    evt_meta_ff;
  logic [N_EVT-1:0]    evt_sync_ff;
  logic [N_EVT-1:0]    evt_en_ff;
  logic [N_EVT-1:0]    evt_stat_ff;
  logic [N_EVT-1:0]    evt_sel;
  logic [N_EVT-1:0]    evt_view;
  logic [7:0]          dac1_sel_ff;
  logic [7:0]          clk_sel_ff;
  logic [7:0]          skip_ff;
  logic [6:0]          tol_ff;
  logic                oneshot_ff;
  logic                rot_done_ff;
  logic                jit_en_ff;
  logic                jit_stat_ff;
  logic                jit_sel_ff;
  logic [7:0]          reg_rdata_ff;
  logic [2:0]          edge_ff;
  logic                edge_rise;
  logic [7:0]          skip_cnt_ff;
  logic [PERIOD_W-1:0] cnt_ff;
  logic [PERIOD_W-1:0] period_ff;
  logic                jit_hit;
  logic                rot_now;
  logic                summary;
  logic                wr_summary_clr;
  logic [N_EVT-1:0]    wr_evt_clr;
  logic                wr_jit_clr;
  logic                wr_dac1_sel;
  logic                wr_clk_sel;
  logic                wr_skip;
  logic                wr_tol;
  logic                wr_evt_en;
  logic                wr_evt_stat;
  logic                wr_jit_en;
  logic                wr_jit_stat;
  logic                wr_jit_sel;
  logic                wr_mode_arm;
  logic                pin_a_req;
  logic                pin_b_req;
  logic [7:0]          mode_view;
  irqsync_sync_e       sync_st_ff;
  irqsync_sync_e       nxt_sync_st;

  assign evt_sel = {dac1_sel_ff[`IRQSYNC_BIT_PAERR],
                    clk_sel_ff[`IRQSYNC_BIT_DLL_LOST],
                    clk_sel_ff[`IRQSYNC_BIT_DLL_LOCK],
                    clk_sel_ff[`IRQSYNC_BIT_PLL_LOST],
                    clk_sel_ff[`IRQSYNC_BIT_PLL_LOCK]};

  // write decode, one strobe per register
  assign wr_dac1_sel    = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_DAC1_SEL);
  assign wr_clk_sel     = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_CLK_SEL);
  assign wr_skip        = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_SKIP);
  assign wr_tol         = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_JIT_TOL);
  assign wr_evt_en      = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_EVT_EN);
  assign wr_evt_stat    = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_EVT_STAT);
  assign wr_jit_en      = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_JIT_EN);
  assign wr_jit_stat    = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_JIT_STAT);
  assign wr_jit_sel     = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_JIT_SEL);
  assign wr_mode_arm    = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_MODE)
                          && reg_wdata_i[`IRQSYNC_BIT_ONESHOT];
  assign wr_summary_clr = reg_wr_i && (reg_addr_i == `IRQSYNC_OFS_SUMMARY) && reg_wdata_i[0];
  assign wr_jit_clr     = (wr_jit_stat && reg_wdata_i[0]) || wr_summary_clr;

  // event synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      evt_meta_ff <= '0;
      evt_sync_ff <= '0;
    end else begin
      evt_meta_ff <= evt_i;
      evt_sync_ff <= evt_meta_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_EVT; g++) begin : g_evt
      assign wr_evt_clr[g] = (wr_evt_stat && reg_wdata_i[g]) || wr_summary_clr;
      // set wins over clear
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          evt_stat_ff[g] <= 1'b0;
        end else if (!evt_en_ff[g]) begin
          evt_stat_ff[g] <= 1'b0;
        end else if (evt_sync_ff[g]) begin
          evt_stat_ff[g] <= 1'b1;
        end else if (wr_evt_clr[g]) begin
          evt_stat_ff[g] <= 1'b0;
        end
      end
      assign evt_view[g] = evt_en_ff[g] ? evt_stat_ff[g] : evt_sync_ff[g];
    end
  endgenerate

  assign summary = (|evt_view) || jit_stat_ff;

  // active-low pins, selector 0 to pin a and 1 to pin b
  assign pin_a_req = (|(evt_stat_ff & ~evt_sel)) || (jit_stat_ff && !jit_sel_ff);
  assign pin_b_req = (|(evt_stat_ff & evt_sel)) || (jit_stat_ff && jit_sel_ff);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      interrupt_pin_a_n_o <= 1'b1;
    end else begin
      interrupt_pin_a_n_o <= !pin_a_req;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      interrupt_pin_b_n_o <= 1'b1;
    end else begin
      interrupt_pin_b_n_o <= !pin_b_req;
    end
  end

  assign irq_o = (|evt_stat_ff) || jit_stat_ff;

  // control registers, one process each
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dac1_sel_ff <= `IRQSYNC_RST_BYTE;
    end else if (wr_dac1_sel) begin
      dac1_sel_ff <= {7'h0_0, reg_wdata_i[`IRQSYNC_BIT_PAERR]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_sel_ff <= `IRQSYNC_RST_BYTE;
    end else if (wr_clk_sel) begin
      clk_sel_ff <= reg_wdata_i & `IRQSYNC_CLK_MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      skip_ff <= `IRQSYNC_RST_BYTE;
    end else if (wr_skip) begin
      skip_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tol_ff <= 7'h0_0;
    end else if (wr_tol) begin
      tol_ff <= reg_wdata_i[6:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      evt_en_ff <= '0;
    end else if (wr_evt_en) begin
      evt_en_ff <= reg_wdata_i[N_EVT-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jit_en_ff <= 1'b0;
    end else if (wr_jit_en) begin
      jit_en_ff <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jit_sel_ff <= 1'b0;
    end else if (wr_jit_sel) begin
      jit_sel_ff <= reg_wdata_i[0];
    end
  end

  // sync edge: two-stage synchroniser, third stage for edge detect
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      edge_ff <= 3'h0;
    end else begin
      edge_ff <= {edge_ff[1:0], sync_edge_i};
    end
  end
  assign edge_rise = edge_ff[1] && !edge_ff[2];

  always_comb begin
    nxt_sync_st = sync_st_ff;
    unique case (sync_st_ff)
      IRQSYNC_WAIT: if (oneshot_ff) nxt_sync_st = IRQSYNC_SKIP;
      IRQSYNC_SKIP: if (edge_rise && skip_cnt_ff == skip_ff) nxt_sync_st = IRQSYNC_MON;
      IRQSYNC_MON:  if (oneshot_ff) nxt_sync_st = IRQSYNC_SKIP;
      default:      nxt_sync_st = IRQSYNC_WAIT;
    endcase
  end
  assign rot_now = (sync_st_ff == IRQSYNC_SKIP) && edge_rise && (skip_cnt_ff == skip_ff);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_st_ff <= IRQSYNC_WAIT;
    end else begin
      sync_st_ff <= nxt_sync_st;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || sync_st_ff != IRQSYNC_SKIP) begin
      skip_cnt_ff <= 8'h0_0;
    end else if (edge_rise) begin
      skip_cnt_ff <= skip_cnt_ff + 8'h0_1;
    end
  end

  // one-shot arms a rotation, self-clears once performed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oneshot_ff <= 1'b0;
    end else if (rot_now) begin
      oneshot_ff <= 1'b0;
    end else if (wr_mode_arm) begin
      oneshot_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rot_done_ff <= `IRQSYNC_RST_ROT_DONE;
    end else if (rot_now) begin
      rot_done_ff <= 1'b1;
    end else if (wr_mode_arm) begin
      rot_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rotate_pulse_o <= !rst_i && rot_now;
  end

  // cycles since the last edge, saturating
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || edge_rise) begin
      cnt_ff <= '0;
    end else if (cnt_ff != '1) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // period learnt from the last interval before the rotation
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      period_ff <= '0;
    end else if (edge_rise && (sync_st_ff != IRQSYNC_MON || rot_now)) begin
      period_ff <= cnt_ff;
    end
  end

  // monitor checks |cnt - period| > tolerance at each edge
  assign jit_hit = edge_rise && (sync_st_ff == IRQSYNC_MON) && !oneshot_ff &&
                   (((cnt_ff > period_ff) ? (cnt_ff - period_ff) : (period_ff - cnt_ff))
                    > PERIOD_W'(tol_ff));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jit_stat_ff <= 1'b0;
    end else if (jit_hit && jit_en_ff) begin
      jit_stat_ff <= 1'b1;
    end else if (wr_jit_clr || !jit_en_ff) begin
      jit_stat_ff <= 1'b0;
    end
  end

  assign mode_view = {3'h0, rot_done_ff, 2'h0, oneshot_ff, 1'b0};

  // read data one cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !reg_rd_i) begin
      reg_rdata_ff <= 8'h0_0;
    end else begin
      unique case (reg_addr_i)
        `IRQSYNC_OFS_DAC1_SEL: reg_rdata_ff <= dac1_sel_ff;
        `IRQSYNC_OFS_CLK_SEL:  reg_rdata_ff <= clk_sel_ff;
        `IRQSYNC_OFS_SUMMARY:  reg_rdata_ff <= {7'h0_0, summary};
        `IRQSYNC_OFS_EVT_EN:   reg_rdata_ff <= {{(8-N_EVT){1'b0}}, evt_en_ff};
        `IRQSYNC_OFS_EVT_STAT: reg_rdata_ff <= {{(8-N_EVT){1'b0}}, evt_view};
        `IRQSYNC_OFS_JIT_EN:   reg_rdata_ff <= {7'h0_0, jit_en_ff};
        `IRQSYNC_OFS_JIT_STAT: reg_rdata_ff <= {7'h0_0, jit_stat_ff};
        `IRQSYNC_OFS_JIT_SEL:  reg_rdata_ff <= {7'h0_0, jit_sel_ff};
        `IRQSYNC_OFS_SKIP:     reg_rdata_ff <= skip_ff;
        `IRQSYNC_OFS_JIT_TOL:  reg_rdata_ff <= {1'b0, tol_ff};
        `IRQSYNC_OFS_MODE:     reg_rdata_ff <= mode_view;
        default:               reg_rdata_ff <= 8'h0_0;
      endcase
    end
  end
  assign reg_rdata_o = reg_rdata_ff;

endmodule

`default_nettype wire

// ### tb/irqsync_props.sv
/* assertions on the routing and sync monitor top ports.
   assumes a bind from the bench top and the shared defines header. */
`timescale 1ns/100ps
`default_nettype none
`include "irqsync_defs.svh"
module irqsync_props (
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire logic [`IRQSYNC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]                 reg_wdata_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [7:0]                 reg_rdata_o,
  input wire irqsync_pkg::irqsync_evt_s  evt_i,
  input wire logic                       sync_edge_i,
  input wire logic                       rotate_pulse_o,
  input wire logic                       interrupt_pin_a_n_o,
  input wire logic                       interrupt_pin_b_n_o,
  input wire logic                       irq_o
);
  import irqsync_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  reset_outs_a: assert property (disable iff (1'b0) rst_i |=> interrupt_pin_a_n_o
    && interrupt_pin_b_n_o && !irq_o && !rotate_pulse_o && reg_rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  sum_read_a: assert property (reg_rd_i && reg_addr_i == `IRQSYNC_OFS_SUMMARY && irq_o
    |=> reg_rdata_o == 8'h01) else $error("summary read wrong");
  mode_read_a: assert property (reg_rd_i && reg_addr_i == `IRQSYNC_OFS_MODE
    |=> (reg_rdata_o & 8'hED) == 8'h00) else $error("mode reserved bits set");
  tol_read_a: assert property (reg_rd_i && reg_addr_i == `IRQSYNC_OFS_JIT_TOL
    |=> !reg_rdata_o[7]) else $error("tolerance bit 7 set");
  sel_read_a: assert property (reg_rd_i && reg_addr_i == `IRQSYNC_OFS_CLK_SEL
    |=> (reg_rdata_o & 8'hCC) == 8'h00) else $error("select reserved bits set");
  pins_irq_a: assert property ((!interrupt_pin_a_n_o || !interrupt_pin_b_n_o)
    == $past(irq_o)) else $error("pins disagree with irq");
  rot_pulse_a: assert property (rotate_pulse_o |=> !rotate_pulse_o)
    else $error("rotate pulse too long");
  arm_done_a: assert property (reg_wr_i && reg_addr_i == `IRQSYNC_OFS_MODE && reg_wdata_i[1]
    ##2 reg_rd_i && reg_addr_i == `IRQSYNC_OFS_MODE |=> !reg_rdata_o[4])
    else $error("done flag not cleared on arm");
  sum_clear_a: assert property (reg_wr_i && reg_addr_i == `IRQSYNC_OFS_SUMMARY
    && reg_wdata_i[0] && evt_i == '0 && $past(evt_i) == '0 && $past(evt_i, 2) == '0
    && !($past(sync_edge_i, 2) && !$past(sync_edge_i, 3))
    |=> ##1 interrupt_pin_a_n_o && interrupt_pin_b_n_o) else $error("pins held after clear");
  cover property (rotate_pulse_o);
  cover property (!interrupt_pin_b_n_o);
  cover property (!interrupt_pin_a_n_o && irq_o);
endmodule
`default_nettype wire

// ### tb/irqsync_host_model.sv
/* host that services the two active-low interrupt pins.
   assumes pins are levels in the sys_clk_i domain; ack_i forgets what was seen. */
`timescale 1ns/100ps
`default_nettype none
module irqsync_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       pin_a_n_i,
  input  wire logic       pin_b_n_i,
  input  wire logic       ack_i,
  output logic      [1:0] seen_o
);
  // remembers which pin has been pulled low, as {b, a}
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || ack_i) begin
      seen_o <= 2'b00;
    end else begin
      seen_o <= seen_o | {!pin_b_n_i, !pin_a_n_i};
    end
  end
endmodule
`default_nettype wire

// ### tb/irqsync_tb.sv
/* self-checking bench for the routing and sync monitor block.
   assumes the design files and the host model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "irqsync_defs.svh"
module irqsync_tb;
  import irqsync_pkg::*;
  logic                       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sync = 1'b0, ack = 1'b0;
  logic [`IRQSYNC_ADDR_W-1:0] addr = '0;
  logic [7:0]                 wdata = 8'h00, rdata;
  irqsync_evt_s               evt = '0;
  logic                       rot, pa_n, pb_n, irq;
  logic [1:0]                 seen;
  int                         n_errors = 0, samples_checked = 0, n_rot = 0;
  irqsync_top dut_u (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .evt_i(evt), .sync_edge_i(sync),
    .rotate_pulse_o(rot), .interrupt_pin_a_n_o(pa_n), .interrupt_pin_b_n_o(pb_n), .irq_o(irq));
  irqsync_host_model host_u (.sys_clk_i(clk), .rst_i(rst), .pin_a_n_i(pa_n), .pin_b_n_i(pb_n),
    .ack_i(ack), .seen_o(seen));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rot) n_rot++;
  end
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic gap(input int n, input logic [1:0] pins);
    @(posedge clk) sync <= 1'b0;
    repeat (n - 2) @(posedge clk);
    #1 chk("pins", {6'h00, pb_n, pa_n}, {6'h00, pins});
    @(posedge clk) sync <= 1'b1;
  endtask
  initial begin
    #200000 n_errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(`IRQSYNC_OFS_CLK_SEL, 8'h00); rdc(`IRQSYNC_OFS_SUMMARY, 8'h00);
    rdc(`IRQSYNC_OFS_SKIP, 8'h00); rdc(`IRQSYNC_OFS_MODE, 8'h10);
    rdc(12'h1_00, 8'h00); wrr(`IRQSYNC_OFS_JIT_TOL, 8'hFF);
    rdc(`IRQSYNC_OFS_JIT_TOL, 8'h7F); wrr(`IRQSYNC_OFS_CLK_SEL, 8'hFF);
    rdc(`IRQSYNC_OFS_CLK_SEL, 8'h33);
    wrr(`IRQSYNC_OFS_EVT_EN, 8'h1F);
    for (int s = 0; s < 2; s++) begin
      wrr(`IRQSYNC_OFS_DAC1_SEL, 8'(s));
      wrr(`IRQSYNC_OFS_CLK_SEL, s ? 8'h33 : 8'h00);
      for (int i = 0; i < 5; i++) begin
        evt <= irqsync_evt_s'(5'h01 << i);
        repeat (6) @(posedge clk);
        evt <= '0;
        repeat (4) @(posedge clk);
        chk("pins", {6'h00, pb_n, pa_n}, s ? 8'h01 : 8'h02);
        chk("host", {6'h00, seen}, s ? 8'h02 : 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        rdc(`IRQSYNC_OFS_SUMMARY, 8'h01);
        if (i % 2) wrr(`IRQSYNC_OFS_SUMMARY, 8'h01);
        else wrr(`IRQSYNC_OFS_EVT_STAT, 8'(8'h01 << i));
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        chk("pins", {6'h00, pb_n, pa_n}, 8'h03);
        rdc(`IRQSYNC_OFS_SUMMARY, 8'h00);
      end
    end
    wrr(`IRQSYNC_OFS_EVT_EN, 8'h00);
    evt <= irqsync_evt_s'(5'h10);
    repeat (6) @(posedge clk);
    chk("pins", {6'h00, pb_n, pa_n}, 8'h03);
    rdc(`IRQSYNC_OFS_EVT_STAT, 8'h10);
    evt <= '0;
    repeat (6) @(posedge clk);
    rdc(`IRQSYNC_OFS_EVT_STAT, 8'h00);
    wrr(`IRQSYNC_OFS_JIT_EN, 8'h01); wrr(`IRQSYNC_OFS_JIT_TOL, 8'h03);
    wrr(`IRQSYNC_OFS_JIT_SEL, 8'h01);
    wrr(`IRQSYNC_OFS_SKIP, 8'h02); wrr(`IRQSYNC_OFS_MODE, 8'h02);
    rdc(`IRQSYNC_OFS_MODE, 8'h02);
    gap(20, 2'b11); gap(20, 2'b11);
    chk("rotations", 8'h00, 8'(n_rot));
    gap(20, 2'b11); gap(23, 2'b11);
    chk("rotations", 8'h01, 8'(n_rot));
    gap(24, 2'b11);
    gap(20, 2'b01);
    repeat (6) @(posedge clk);
    rdc(`IRQSYNC_OFS_MODE, 8'h10);
    rdc(`IRQSYNC_OFS_JIT_STAT, 8'h01);
    wrr(`IRQSYNC_OFS_SUMMARY, 8'h01);
    rdc(`IRQSYNC_OFS_JIT_STAT, 8'h00);
    end_of_test();
  end
endmodule
bind irqsync_top irqsync_props props_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .evt_i(evt_i), .sync_edge_i(sync_edge_i),
  .rotate_pulse_o(rotate_pulse_o), .interrupt_pin_a_n_o(interrupt_pin_a_n_o),
  .interrupt_pin_b_n_o(interrupt_pin_b_n_o), .irq_o(irq_o));
`default_nettype wire
